// ---- sim/sdrgc_config_chk.sv ----
// port checker for sdrgc_config: geometry, init restart, refresh, chip selects
// assumes an avalon master that holds each request until waitrequest is low
module sdrgc_config_chk
  import sdrgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic accessValid,
  input wire logic initStart,
  input wire logic refreshReq,
  input wire logic [3:0] bankCount,
  input wire logic [3:0] colAddrBits,
  input wire logic chip_sel_0_n,
  input wire logic chip_sel_1_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take; // a write takes effect at this edge
  logic inhQ; // mirrored inhibit bit
  logic csQ; // mirrored chip select count
  logic [1:0] pageQ; // mirrored page field
  logic [1:0] bankQ; // mirrored bank field
  assign take = write & ~waitrequest;
  // mirror only the fields the properties need, from bus traffic alone
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      inhQ <= 1'h1;
      csQ <= 1'h0;
      pageQ <= 2'h0;
      bankQ <= 2'h0;
    end
    else
    begin
      if (take && address == 4'h0 && byteenable[0])
      begin
        csQ <= writedata[3];
        pageQ <= writedata[1:0];
        bankQ <= writedata[6:5];
      end
      if (take && address == 4'h4 && byteenable[3])
        inhQ <= writedata[31];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_init_cfg;
    take && address == 4'h0 && byteenable[0] && !inhQ |-> ##[1:2] initStart;
  endproperty
  property p_init_quiet;
    inhQ && $past(inhQ) |-> !initStart;
  endproperty
  property p_init_pulse;
    initStart |=> !initStart;
  endproperty
  // two cycles of slack cover a pulse already in flight when inhibit lands
  property p_ref_inhibit;
    inhQ && $past(inhQ) && $past(inhQ, 2) |-> !refreshReq;
  endproperty
  property p_bank;
    bankQ == $past(bankQ) && bankQ == $past(bankQ, 2) |-> bankCount == (4'h1 << bankQ);
  endproperty
  property p_cols;
    pageQ == $past(pageQ) && pageQ == $past(pageQ, 2) |-> colAddrBits == 4'h8 + pageQ;
  endproperty
  property p_cs_one;
    accessValid && !csQ |=> !chip_sel_0_n && chip_sel_1_n;
  endproperty
  property p_rsv_cfg;
    read && !waitrequest && address == 4'h0 |-> readdata[4] == 1'h0 && readdata[2] == 1'h0;
  endproperty
  property p_rsv_ref;
    read && !waitrequest && address == 4'h4 |-> readdata[30:16] == 15'h0;
  endproperty
  a_init_cfg: assert property (p_init_cfg) else $error("no init after config write");
  a_init_quiet: assert property (p_init_quiet) else $error("init while inhibited");
  a_init_pulse: assert property (p_init_pulse) else $error("init pulse too long");
  a_ref_inhibit: assert property (p_ref_inhibit) else $error("refresh while inhibited");
  a_bank: assert property (p_bank) else $error("bank count wrong");
  a_cols: assert property (p_cols) else $error("column bits wrong");
  a_cs_one: assert property (p_cs_one) else $error("second select used");
  a_rsv_cfg: assert property (p_rsv_cfg) else $error("config reserved bit set");
  a_rsv_ref: assert property (p_rsv_ref) else $error("refresh reserved bits set");
  c_refresh: cover property (refreshReq);
  c_init: cover property (initStart);
  c_rank1: cover property (accessValid ##1 !chip_sel_1_n);
endmodule

bind sdrgc_config sdrgc_config_chk u_chk (.*);

// ---- sim/sdrgc_sched_model.sv ----
// scheduler stand-in that answers the self-refresh handshake
// assumes selfRefreshReq is a level; ackDelay 0 answers promptly
module sdrgc_sched_model
#(
  parameter int ackDelay = 3
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic selfRefreshReq,
  output logic selfRefreshAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitQ; // cycles spent since the request changed level
  // ack follows the request level late, as a busy scheduler would
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      waitQ <= 4'h0;
      selfRefreshAck <= 1'h0;
    end
    else if (selfRefreshReq == selfRefreshAck)
      waitQ <= 4'h0;
    else if (waitQ == ackDelay[3:0])
      selfRefreshAck <= selfRefreshReq;
    else
      waitQ <= waitQ + 4'h1;
  end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the sdram geometry and refresh configuration block
// assumes sdrgc_sched_model stands in for the scheduler's handshake
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] address = 4'h0;
  logic [3:0] byteenable = 4'h0;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic memClkEn = 1'h1; // memory clock equals core clock
  logic deviceX16 = 1'h0;
  logic accessValid = 1'h0;
  logic [31:0] accessAddr = 32'h0;
  logic [31:0] readdata, rdv;
  logic waitrequest, selfRefreshAck, selfRefreshReq, initStart, refreshReq, chip_sel_0_n, chip_sel_1_n;
  logic [3:0] bankCount, colAddrBits;
  logic [12:0] pageBytes;
  logic [2:0] bankAddr;
  logic [10:0] colAddr;
  logic [15:0] rowAddr;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int initCnt = 0;
  int refCnt = 0;
  int refGap = 0;
  int lastGap = 0;
  int n;
  sdrgc_config dut (.*);
  sdrgc_sched_model #(.ackDelay(3)) partner (.*);
  always #4 core_clk = ~core_clk;
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer: the request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    // read right after the edge, so the values are those that edge sampled
    @(posedge core_clk);
    while (waitrequest !== 1'h0)
    begin
      @(posedge core_clk);
    end
    rdv = readdata;
    write <= 1'h0;
    read <= 1'h0;
  endtask
  task automatic access(input logic [31:0] a, input logic [1:0] cs, input logic [10:0] col, input logic [2:0] bank,
    input logic [15:0] row);
    @(posedge core_clk);
    accessValid <= 1'h1;
    accessAddr <= a;
    @(posedge core_clk);
    accessValid <= 1'h0;
    @(negedge core_clk);
    chk({chip_sel_1_n, chip_sel_0_n}, cs);
    chk(colAddr, col);
    chk(bankAddr, bank);
    chk(rowAddr, row);
  endtask
  // pulse counters, refresh spacing and the hang limit
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (initStart === 1'h1)
      initCnt <= initCnt + 1;
    refGap <= (refreshReq === 1'h1) ? 1 : refGap + 1;
    if (refreshReq === 1'h1)
    begin
      refCnt <= refCnt + 1;
      lastGap <= refGap;
    end
    if (cyc == 5000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    bus(0, 4'h0, 32'h0, 4'hF);
    chk(rdv, 32'h0);
    bus(0, 4'h4, 32'h0, 4'hF);
    chk(rdv, 32'h80000000);
    // reserved ones are written to prove they are dropped
    bus(1, 4'h4, 32'h7FFF0005, 4'hF);
    bus(0, 4'h4, 32'h0, 4'hF);
    chk(rdv, 32'h5);
    repeat (20) @(posedge core_clk);
    chk(lastGap, 5);
    bus(1, 4'h4, 32'h80000005, 4'hF);
    repeat (3) @(posedge core_clk);
    n = refCnt;
    repeat (20) @(posedge core_clk);
    chk(refCnt, n);
    bus(1, 4'h4, 32'h100, 4'hF);
    // every geometry code, the first one equal to the value already held
    for (int i = 0; i < 4; i++)
    begin
      deviceX16 <= i[0];
      n = initCnt;
      bus(1, 4'h0, 32'hFFFFFF94 | (i << 5) | i, 4'h1);
      bus(0, 4'h0, 32'h0, 4'hF);
      chk(rdv, (i << 5) | i);
      chk(initCnt, n + 1);
      chk(bankCount, 1 << i);
      chk(colAddrBits, 8 + i);
      chk(pageBytes, (256 << i) * (i % 2 + 1));
    end
    // a geometry write under inhibit waits in status until inhibit clears
    n = initCnt;
    bus(1, 4'h4, 32'h80000100, 4'hF);
    bus(1, 4'h0, 32'h8, 4'h1);
    bus(0, 4'hC, 32'h0, 4'hF);
    chk(rdv, 32'h2);
    chk(initCnt, n);
    bus(1, 4'h4, 32'h100, 4'hF);
    bus(0, 4'hC, 32'h0, 4'hF);
    chk(rdv, 32'h0);
    chk(initCnt, n + 1);
    access(32'h1A5, 2'h1, 11'hA5, 3'h0, 16'h0000);
    bus(1, 4'h0, 32'h0, 4'h1);
    access(32'h1A5, 2'h2, 11'hA5, 3'h0, 16'h0001);
    // eight banks, 512-word page, two selects: row 2B, select 1, bank 5, column 1A5
    bus(1, 4'h0, 32'h69, 4'h1);
    access(32'h57BA5, 2'h1, 11'h1A5, 3'h5, 16'h002B);
    bus(0, 4'h2, 32'h0, 4'hF);
    chk(rdv, 32'h0);
    bus(1, 4'h8, 32'h1, 4'h1);
    repeat (8) @(posedge core_clk);
    bus(0, 4'hC, 32'h0, 4'hF);
    chk(rdv, 32'h1);
    bus(1, 4'h8, 32'h0, 4'h1);
    repeat (8) @(posedge core_clk);
    bus(0, 4'hC, 32'h0, 4'hF);
    chk(rdv, 32'h0);
    give_verdict();
  end
endmodule

// ---- src/sdrgc_config.sv ----
// sdram geometry, chip-select and refresh configuration registers
// assumes an avalon-mm master on core_clk and a scheduler that accepts
// initStart, refreshReq and the self-refresh handshake
`include "sdrgc_params.svh"

// How it works
// - bank field 1,2,3 means 2,4,8 banks
// - bank field 0 means one bank
// - bank field write restarts initialization
// - chip select bit picks one or two selects
// - reserved bits read zero, writes ignored
// - page field gives 256..2048 words, 8..11 column bits
// - page field write restarts initialization
// - a page word is one device width
// - inhibit bit defers init and skips refresh only
// - refresh every refresh_interval memory clocks
// - software enters and leaves self-refresh
module sdrgc_config
  import sdrgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // memory clock enable and device data width
  input wire logic memClkEn,
  input wire logic deviceX16,
  // access address from the scheduler, in device words
  input wire logic accessValid,
  input wire logic [31:0] accessAddr,
  // self-refresh handshake
  input wire logic selfRefreshAck,
  output logic selfRefreshReq,
  // geometry toward the scheduler
  output logic initStart,
  output logic refreshReq,
  output logic [3:0] bankCount,
  output logic [3:0] colAddrBits,
  output logic [12:0] pageBytes,
  output logic [2:0] bankAddr,
  output logic [10:0] colAddr,
  output logic [15:0] rowAddr,
  output logic chip_sel_0_n,
  output logic chip_sel_1_n
);

  // number of column address bits for a page-size code
  function automatic logic [3:0] colBitsOf(input logic [1:0] page);
    colBitsOf = `SDRGC_MIN_COL_BITS + {2'b00, page};
  endfunction

  logic [1:0] bankField_q; // internal_bank_count
  logic chipSelCount_q; // chip_select_count
  logic [1:0] pageField_q; // column_page_size
  logic initRefreshInhibit_q; // init_refresh_inhibit
  logic [15:0] refreshInterval_q; // refresh_interval
  logic selfRefreshCmd_q; // software wish to sleep
  logic ack_q; // bus answer phase
  logic initPending_q; // init asked while inhibited
  sdrgc_sr_state_t srState_q; // self-refresh handshake state
  logic busReq; // a request is on the bus
  logic wrTaken; // write takes effect this edge
  logic geomWrite; // write hits bank or page fields
  logic [31:0] rdValue; // read mux
  logic [3:0] bankBits; // bank address width
  logic [31:0] shifted; // address after column bits
  logic [31:0] afterBank; // address after bank bits
  logic [1:0] csSelect; // per-select enable

  // one wait cycle then answer; request held by the master meanwhile
  assign busReq = read || write;
  assign waitrequest = busReq && !ack_q;
  assign wrTaken = write && ack_q;
  // any write to the low byte of sdram_config touches bank and page fields
  assign geomWrite = wrTaken && (address == `SDRGC_OFS_SDRAM_CONFIG) && byteenable[0];

  // answer phase toggles so every request gets exactly one wait cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= busReq && !ack_q;
  end

  // sdram_config geometry fields
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bankField_q <= `SDRGC_RST_BANK;
      chipSelCount_q <= `SDRGC_RST_CS;
      pageField_q <= `SDRGC_RST_PAGE;
    end
    else if (geomWrite)
    begin
      // reserved bits 4 and 2 have no storage
      bankField_q <= writedata[`SDRGC_BANK_MSB:`SDRGC_BANK_LSB];
      chipSelCount_q <= writedata[`SDRGC_CS_BIT];
      pageField_q <= writedata[`SDRGC_PAGE_MSB:`SDRGC_PAGE_LSB];
    end
  end

  // refresh_control fields, per byte lane
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      initRefreshInhibit_q <= `SDRGC_RST_INHIBIT;
      refreshInterval_q <= `SDRGC_RST_INTERVAL;
    end
    else if (wrTaken && (address == `SDRGC_OFS_REFRESH_CONTROL))
    begin
      if (byteenable[3])
        initRefreshInhibit_q <= writedata[`SDRGC_INHIBIT_BIT];
      if (byteenable[0])
        refreshInterval_q[7:0] <= writedata[7:0];
      if (byteenable[1])
        refreshInterval_q[15:8] <= writedata[15:8];
    end
  end

  // software self-refresh command
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      selfRefreshCmd_q <= 1'b0;
    else if (wrTaken && (address == `SDRGC_OFS_SELF_REFRESH) && byteenable[0])
      selfRefreshCmd_q <= writedata[0];
  end

  // init restart: pulse now, or remember it until inhibit is cleared
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      initStart <= 1'b0;
      initPending_q <= 1'b0;
    end
    else
    begin
      // inhibit suppresses the sequence but keeps the request for later
      initStart <= (geomWrite || initPending_q) && !initRefreshInhibit_q;
      if (geomWrite && initRefreshInhibit_q)
        initPending_q <= 1'b1;
      else if (!initRefreshInhibit_q)
        initPending_q <= 1'b0;
    end
  end

  // self-refresh handshake; the scheduler acknowledges entry and exit
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      srState_q <= SR_AWAKE;
    else
    begin
      case (srState_q)
        SR_AWAKE:
          if (selfRefreshCmd_q)
            srState_q <= SR_ENTERING;
        SR_ENTERING:
          if (selfRefreshAck)
            srState_q <= SR_ASLEEP;
        SR_ASLEEP:
          if (!selfRefreshCmd_q)
            srState_q <= SR_LEAVING;
        SR_LEAVING:
          if (!selfRefreshAck)
            srState_q <= SR_AWAKE;
        default: srState_q <= SR_AWAKE;
      endcase
    end
  end

  assign selfRefreshReq = (srState_q == SR_ENTERING) || (srState_q == SR_ASLEEP);

  // register read mux; unmapped addresses read zero
  always_comb
  begin
    rdValue = 32'h0000_0000;
    case (address)
      `SDRGC_OFS_SDRAM_CONFIG:
      begin
        rdValue[`SDRGC_BANK_MSB:`SDRGC_BANK_LSB] = bankField_q;
        rdValue[`SDRGC_CS_BIT] = chipSelCount_q;
        rdValue[`SDRGC_PAGE_MSB:`SDRGC_PAGE_LSB] = pageField_q;
      end
      `SDRGC_OFS_REFRESH_CONTROL:
      begin
        rdValue[`SDRGC_INHIBIT_BIT] = initRefreshInhibit_q;
        rdValue[`SDRGC_INTERVAL_MSB:`SDRGC_INTERVAL_LSB] = refreshInterval_q;
      end
      `SDRGC_OFS_SELF_REFRESH:
        rdValue[0] = selfRefreshCmd_q;
      `SDRGC_OFS_STATUS:
      begin
        rdValue[0] = (srState_q == SR_ASLEEP);
        rdValue[1] = initPending_q;
      end
      default: rdValue = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, valid at the answer edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (read && !ack_q)
      readdata <= rdValue;
  end

  // geometry decode: bank field 0 is one bank, 1..3 double each step
  assign bankBits = {2'b00, bankField_q};

  // static geometry outputs, registered
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bankCount <= 4'h1;
      colAddrBits <= `SDRGC_MIN_COL_BITS;
      pageBytes <= 13'h0100;
    end
    else
    begin
      bankCount <= 4'(4'h1 << bankBits);
      colAddrBits <= colBitsOf(pageField_q);
      // a page word is one device wide: x8 one byte, x16 two
      pageBytes <= 13'(13'h0001 << (colBitsOf(pageField_q) + {3'b000, deviceX16}));
    end
  end

  // split a word address into column, bank, select and row
  assign shifted = accessAddr >> colBitsOf(pageField_q);
  assign afterBank = shifted >> bankBits;

  // address fields registered so they line up with the chip selects
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      colAddr <= 11'h000;
      bankAddr <= 3'h0;
      rowAddr <= 16'h0000;
    end
    else if (accessValid)
    begin
      colAddr <= accessAddr[10:0] & 11'(~(11'h7FF << colBitsOf(pageField_q)));
      bankAddr <= shifted[2:0] & 3'(~(3'h7 << bankBits));
      // second select takes one address bit above the banks
      rowAddr <= chipSelCount_q ? afterBank[16:1] : afterBank[15:0];
    end
  end

  // which select an access uses
  assign csSelect[0] = !chipSelCount_q || !afterBank[0];
  assign csSelect[1] = chipSelCount_q && afterBank[0];

  // active-low chip selects, one flop each
  logic [1:0] chipSelN_q;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_cs
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          chipSelN_q[gi] <= 1'b1;
        else
          chipSelN_q[gi] <= !(accessValid && csSelect[gi]);
      end
    end
  endgenerate

  assign chip_sel_0_n = chipSelN_q[0];
  assign chip_sel_1_n = chipSelN_q[1];

  // auto-refresh timer; self-refresh holds it reloaded, a new init restarts it
  sdrgc_refresh_timer u_refresh_timer (
    .core_clk(core_clk),
    .rst(rst),
    .memClkEn(memClkEn),
    .refreshInterval(refreshInterval_q),
    .refreshInhibit(initRefreshInhibit_q || selfRefreshReq),
    .restart(initStart),
    .refreshReq(refreshReq)
  );

endmodule

// ---- src/sdrgc_params.svh ----
// constants for the sdram geometry and refresh configuration slice
// assumes a 32-bit avalon-mm slave with byte addresses, one core clock
`ifndef SDRGC_PARAMS_SVH
`define SDRGC_PARAMS_SVH

// register byte offsets
`define SDRGC_OFS_SDRAM_CONFIG 4'h0
`define SDRGC_OFS_REFRESH_CONTROL 4'h4
`define SDRGC_OFS_SELF_REFRESH 4'h8
`define SDRGC_OFS_STATUS 4'hC

// sdram_config field positions
`define SDRGC_BANK_LSB 5
`define SDRGC_BANK_MSB 6
`define SDRGC_CS_BIT 3
`define SDRGC_PAGE_LSB 0
`define SDRGC_PAGE_MSB 1

// refresh_control field positions
`define SDRGC_INHIBIT_BIT 31
`define SDRGC_INTERVAL_LSB 0
`define SDRGC_INTERVAL_MSB 15

// reset values
`define SDRGC_RST_BANK 2'h0
`define SDRGC_RST_CS 1'h0
`define SDRGC_RST_PAGE 2'h0
`define SDRGC_RST_INHIBIT 1'h1
`define SDRGC_RST_INTERVAL 16'h0000

// page geometry: least column address width
`define SDRGC_MIN_COL_BITS 4'h8

`endif

// ---- src/sdrgc_pkg.sv ----
// types shared by the sdram geometry and refresh configuration slice
// assumes sdrgc_params.svh holds every numeric constant
package sdrgc_pkg;

  // self-refresh handshake toward the command scheduler
  typedef enum logic [1:0] {
    SR_AWAKE,
    SR_ENTERING,
    SR_ASLEEP,
    SR_LEAVING
  } sdrgc_sr_state_t;

endpackage

// ---- src/sdrgc_refresh_timer.sv ----
// auto-refresh interval timer
// assumes memClkEn pulses once per memory clock, on core_clk
module sdrgc_refresh_timer
  import sdrgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic memClkEn,
  input wire logic [15:0] refreshInterval,
  input wire logic refreshInhibit,
  input wire logic restart,
  output logic refreshReq
);

  // cycles left until the next auto-refresh
  logic [15:0] count_q;

  // reload on expiry or restart, count down once per memory clock
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= 16'h0000;
    end
    else if (restart || refreshInhibit)
    begin
      // while inhibited the counter sits loaded, so release starts a full interval
      count_q <= refreshInterval;
    end
    else if (memClkEn)
    begin
      if (count_q <= 16'h0001)
      begin
        count_q <= refreshInterval;
      end
      else
      begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  // one-cycle request on expiry; a zero interval never asks for refresh
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      refreshReq <= 1'b0;
    end
    else
    begin
      refreshReq <= memClkEn && !restart && !refreshInhibit && (refreshInterval != 16'h0000)
        && (count_q <= 16'h0001);
    end
  end

endmodule
